/* adcs_top.sv */
// converter sequencer with self-calibration, port select and ahb-lite registers
`timescale 1ns/1ns

// Function
// - ten-bit results after on-chip sample-and-hold
// - code 00 timing table rows
// - code 11 timing table rows
// - code 10 timing table rows
// - reset timing gives 120-unit sample
// - self-calibration after every reset
// - busy during calibration, bounded length
// - calibration end sets conversion-done flag
// - control bit 6 powers analog off
// - power-off bit resets to zero
// - mux covers sixteen plus eight channels
// - misc bit 0 picks port group
// - first port group after reset
// - misc register gated by access enable
module adcs_top #(
  parameter int CAL_LEN = adcs_pkg::CAL_CYCLES  // calibration length in cpu clocks
) (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic                   comp_in,
  output adcs_pkg::adcs_analog_type   analog,
  output logic                        irq
);
  import adcs_pkg::*;

  adcs_state_type         state;        // sequencer state
  adcs_state_type         next_state;   // state for the next cycle
  logic [3:0]             chan;         // selected channel
  logic                   ctrl_off;     // analog power off
  logic [1:0]             stc;          // sample time code
  logic [1:0]             ctc;          // conversion time code
  logic                   misc_sel;     // input port select
  logic                   misc_en;      // misc register access enable
  logic [IRQ_WIDTH-1:0]   status;       // sticky events
  logic [IRQ_WIDTH-1:0]   enable;       // interrupt enables
  logic [IRQ_WIDTH-1:0]   next_status;  // status after this cycle
  logic [RES_WIDTH-1:0]   result;       // last result
  logic [RES_WIDTH-1:0]   sar;          // approximation register
  logic [3:0]             bit_idx;      // bit under decision
  logic [TIMER_WIDTH-1:0] cal_cnt;      // calibration progress
  logic                   comp_meta;    // comparator sync, first stage
  logic                   comp_q;       // comparator sync, second stage
  logic                   wr_en;        // write data phase pending
  logic [7:0]             wr_addr;      // offset of pending write
  logic                   tmr_load;     // start a phase
  logic [TIMER_WIDTH-1:0] tmr_val;      // length of the phase
  logic                   tmr_exp;      // last cycle of the phase

  // bus decode
  wire                    addr_ok  = hsel && htrans[1] && hready;
  wire [7:0]              addr_ofs = haddr[7:0];
  wire                    wr_ctrl  = wr_en && (wr_addr == OFS_CTRL);
  wire                    wr_misc  = wr_en && (wr_addr == OFS_MISC) && misc_en;
  wire                    wr_xcfg  = wr_en && (wr_addr == OFS_XCFG);
  wire                    wr_enab  = wr_en && (wr_addr == OFS_ENABLE);
  wire                    wr_clr   = wr_en && (wr_addr == OFS_CLEAR);
  wire                    start_rq = wr_ctrl && hwdata[CTRL_START_BIT];
  wire                    busy     = (state != ST_IDLE);
  wire                    cal_done = (state == ST_CAL) && (cal_cnt == TIMER_WIDTH'(CAL_LEN - 1));
  wire                    conv_end = (state == ST_EXTRA) && tmr_exp && !ctrl_off;
  wire [RES_WIDTH-1:0]    trial    = sar | (RES_WIDTH'(1) << bit_idx);
  wire [1:0]              new_stc  = hwdata[CTRL_STC_LSB +: 2];
  wire [1:0]              new_ctc  = hwdata[CTRL_CTC_LSB +: 2];
  wire                    go       = (state == ST_IDLE) && start_rq && !hwdata[CTRL_OFF_BIT];
  // calibration counts as a finished conversion
  wire                    done_evt = cal_done || conv_end;
  wire                    err_evt  = start_rq && busy;  // start while busy is an error
  wire [IRQ_WIDTH-1:0]    evt      = {err_evt, done_evt};
  wire [IRQ_WIDTH-1:0]    clr_bits = wr_clr ? hwdata[IRQ_WIDTH-1:0] : '0;

  // read mux for the address phase
  wire [31:0] rd_ctrl = {16'h0000, ctc, stc, 3'h0, busy, 1'b0, ctrl_off, 2'h0, chan};
  wire [31:0] rd_data =
      (addr_ofs == OFS_CTRL)   ? rd_ctrl :
      (addr_ofs == OFS_RESULT) ? {22'h000000, result} :
      (addr_ofs == OFS_MISC)   ? {31'h00000000, misc_sel && misc_en} :
      (addr_ofs == OFS_XCFG)   ? (32'(misc_en) << XCFG_MISCEN_BIT) :
      (addr_ofs == OFS_STATUS) ? {30'h00000000, status} :
      (addr_ofs == OFS_ENABLE) ? {30'h00000000, enable} : 32'h00000000;

  // set wins over clear
  assign next_status = (status & ~clr_bits) | evt;

  // phase timer
  adcs_timer u_timer (
    .clock    (clock),
    .srst     (srst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expire   (tmr_exp)
  );

  // sequencer next state and phase loads
  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_val    = '0;
    case (state)
      ST_CAL: begin
        if (cal_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (go) begin
          next_state = ST_SAMPLE;
          tmr_load   = 1'b1;
          tmr_val    = adcs_sample(new_ctc, new_stc);
        end
      end
      ST_SAMPLE: begin
        if (ctrl_off) begin
          next_state = ST_IDLE;
        end else if (tmr_exp) begin
          next_state = ST_COMP;
          tmr_load   = 1'b1;
          tmr_val    = adcs_step(ctc, stc);
        end
      end
      ST_COMP: begin
        if (ctrl_off) begin
          next_state = ST_IDLE;
        end else if (tmr_exp && (bit_idx == 4'h0)) begin
          next_state = ST_EXTRA;
          tmr_load   = 1'b1;
          tmr_val    = adcs_extra(ctc, stc);
        end else if (tmr_exp) begin
          tmr_load   = 1'b1;
          tmr_val    = adcs_step(ctc, stc);
        end
      end
      ST_EXTRA: begin
        if (ctrl_off) begin
          next_state = ST_IDLE;
        end else if (tmr_exp) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state and calibration counter; reset always restarts calibration
  always_ff @(posedge clock) begin
    if (srst) begin
      state   <= ST_CAL;
      cal_cnt <= '0;
    end else begin
      state   <= next_state;
      cal_cnt <= (state == ST_CAL) ? cal_cnt + TIMER_WIDTH'(1) : '0;
    end
  end

  // comparator input from the analog side, two-stage sync
  always_ff @(posedge clock) begin
    if (srst) begin
      comp_meta <= 1'b0;
      comp_q    <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_q    <= comp_meta;
    end
  end

  // successive approximation, msb first
  always_ff @(posedge clock) begin
    if (srst) begin
      sar     <= '0;
      bit_idx <= 4'(RES_WIDTH - 1);
      result  <= '0;
    end else if (go) begin
      sar     <= '0;
      bit_idx <= 4'(RES_WIDTH - 1);
    end else if ((state == ST_COMP) && tmr_exp) begin
      sar     <= comp_q ? trial : sar;
      bit_idx <= bit_idx - 4'h1;
    end else if (conv_end) begin
      result  <= sar;
    end else if (cal_done) begin
      result  <= '0;
    end
  end

  // ahb-lite: zero wait states, address phase capture
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_en   <= addr_ok && hwrite;
      wr_addr <= addr_ofs;
      hrdata  <= (addr_ok && !hwrite) ? rd_data : 32'h00000000;
    end
  end

  // software registers, written in the data phase
  always_ff @(posedge clock) begin
    if (srst) begin
      chan     <= CTRL_RESET[CTRL_CHAN_LSB +: 4];
      ctrl_off <= CTRL_RESET[CTRL_OFF_BIT];
      stc      <= CTRL_RESET[CTRL_STC_LSB +: 2];
      ctc      <= CTRL_RESET[CTRL_CTC_LSB +: 2];
      misc_sel <= MISC_RESET;
      misc_en  <= XCFG_RESET;
      enable   <= '0;
    end else begin
      if (wr_ctrl) begin
        chan     <= hwdata[CTRL_CHAN_LSB +: 4];
        ctrl_off <= hwdata[CTRL_OFF_BIT];
        stc      <= new_stc;
        ctc      <= new_ctc;
      end
      if (wr_misc) begin
        misc_sel <= hwdata[MISC_SEL_BIT];
      end
      if (wr_xcfg) begin
        misc_en  <= hwdata[XCFG_MISCEN_BIT];
      end
      if (wr_enab) begin
        enable   <= hwdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // status flags and interrupt line
  always_ff @(posedge clock) begin
    if (srst) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & enable);
    end
  end

  // analog front-end controls; second group has only eight channels
  always_ff @(posedge clock) begin
    if (srst) begin
      analog    <= '0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      analog.power_off <= ctrl_off;
      analog.sample    <= (next_state == ST_SAMPLE);
      analog.group     <= misc_sel;
      analog.channel   <= misc_sel ? {1'b0, chan[2:0]} : chan;
      analog.dac       <= (state == ST_COMP) ? trial : sar;
      hreadyout        <= 1'b1;
      hresp            <= 1'b0;
    end
  end

  // helper counters for the checks
  logic [TIMER_WIDTH-1:0] ph_cnt;    // cycles spent in current state
  logic [TIMER_WIDTH-1:0] conv_cnt;  // cycles since conversion start
  always_ff @(posedge clock) begin
    if (srst) begin
      ph_cnt   <= '0;
      conv_cnt <= '0;
    end else begin
      ph_cnt   <= (next_state != state) ? '0 : ph_cnt + TIMER_WIDTH'(1);
      conv_cnt <= go ? '0 : conv_cnt + TIMER_WIDTH'(1);
    end
  end

  AST_SAMPLE_LEN: assert property (@(posedge clock) disable iff (srst)
    (state == ST_SAMPLE && next_state == ST_COMP) |-> ph_cnt == adcs_sample(ctc, stc) - 1)
    else $error("sample phase length wrong");
  AST_TOTAL_LEN: assert property (@(posedge clock) disable iff (srst)
    conv_end && !ctrl_off |-> conv_cnt == adcs_total(ctc, stc) - 1)
    else $error("total conversion length wrong");
  AST_RESERVED_CODE: assert property (@(posedge clock) disable iff (srst)
    go && new_ctc == 2'b01 |-> tmr_val == adcs_cycles(SAMPLE_TCL[int'(new_stc)]))
    else $error("code 01 not timed as 00");
  AST_CAL_BUSY: assert property (@(posedge clock) disable iff (srst)
    state == ST_CAL |-> busy && cal_cnt < TIMER_WIDTH'(CAL_LEN))
    else $error("calibration not busy or too long");
  AST_CAL_DONE: assert property (@(posedge clock) disable iff (srst)
    cal_done |=> !busy && status[IRQ_DONE_BIT])
    else $error("calibration end did not set done and clear busy");
  AST_POWER_OFF: assert property (@(posedge clock) disable iff (srst)
    wr_ctrl |=> ##1 analog.power_off == $past(hwdata[CTRL_OFF_BIT], 2))
    else $error("power off bit not applied");
  AST_RESET_DEFAULTS: assert property (@(posedge clock)
    $past(srst) && !srst |-> !ctrl_off && !misc_sel && ctc == 2'b00 && stc == 2'b00)
    else $error("reset defaults wrong");
  AST_MUX_SELECT: assert property (@(posedge clock) disable iff (srst)
    $past(misc_sel) |-> analog.group && !analog.channel[3])
    else $error("second group channel out of range");
  AST_MISC_GATE: assert property (@(posedge clock) disable iff (srst)
    wr_en && wr_addr == OFS_MISC && !misc_en |=> $stable(misc_sel))
    else $error("misc written while access disabled");
  AST_RESULT: assert property (@(posedge clock) disable iff (srst)
    conv_end && !ctrl_off |=> result == $past(sar))
    else $error("result not stored");
  COV_CAL_END: cover property (@(posedge clock) disable iff (srst) cal_done);
  COV_CONV: cover property (@(posedge clock) disable iff (srst) conv_end);
  COV_ERR: cover property (@(posedge clock) disable iff (srst) err_evt);
  COV_GROUP2: cover property (@(posedge clock) disable iff (srst) go && misc_sel);
endmodule

/* adcs_timer.sv */
// package of shared constants and types, and the phase down-counter
package adcs_pkg;
  // clock and converter time base
  localparam int CLK_PERIOD_NS = 100;             // cpu clock period
  localparam int TCL_NS        = 50;              // one clock-phase unit
  localparam int RES_WIDTH     = 10;              // result width in bits
  localparam int CAL_CYCLES    = 40629;           // calibration length, cpu clocks
  localparam int TIMER_WIDTH   = 16;              // width of phase and cal counters
  // timing table in clock-phase units, rows: code 00, 11, 10; columns: sample code
  localparam int SAMPLE_TCL [0:11] = '{120, 140, 200, 400, 240, 280, 400, 800,
                                       480, 560, 800, 1600};
  localparam int EXTRA_TCL  [0:11] = '{28, 16, 52, 44, 52, 28, 100, 52,
                                       100, 52, 196, 164};
  localparam int TOTAL_TCL  [0:11] = '{388, 436, 532, 724, 772, 868, 1060, 1444,
                                       1540, 1732, 2116, 2884};
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;      // converter control
  localparam logic [7:0] OFS_RESULT = 8'h04;      // result data
  localparam logic [7:0] OFS_MISC   = 8'h08;      // miscellaneous
  localparam logic [7:0] OFS_XCFG   = 8'h0C;      // extension peripheral config
  localparam logic [7:0] OFS_STATUS = 8'h10;      // sticky event status
  localparam logic [7:0] OFS_ENABLE = 8'h14;      // interrupt enable
  localparam logic [7:0] OFS_CLEAR  = 8'h18;      // write-one-to-clear
  // field positions
  localparam int CTRL_CHAN_LSB  = 0;              // channel number, 4 bits
  localparam int CTRL_OFF_BIT   = 6;              // analog power off
  localparam int CTRL_START_BIT = 7;              // write one to start
  localparam int CTRL_BUSY_BIT  = 8;              // read-only busy
  localparam int CTRL_STC_LSB   = 12;             // sample time code, 2 bits
  localparam int CTRL_CTC_LSB   = 14;             // conversion time code, 2 bits
  localparam int MISC_SEL_BIT   = 0;              // input port select
  localparam int XCFG_MISCEN_BIT = 10;            // misc register access enable
  localparam int IRQ_DONE_BIT   = 0;              // conversion done
  localparam int IRQ_ERR_BIT    = 1;              // conversion error
  localparam int IRQ_WIDTH      = 2;              // number of events
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;  // codes 00, powered, channel 0
  localparam logic        MISC_RESET = 1'b0;      // first port group
  localparam logic        XCFG_RESET = 1'b0;      // misc access disabled

  // controller states
  typedef enum logic [4:0] {
    ST_CAL    = 5'h01,
    ST_IDLE   = 5'h02,
    ST_SAMPLE = 5'h04,
    ST_COMP   = 5'h08,
    ST_EXTRA  = 5'h10
  } adcs_state_type;

  // signals toward the analog front end
  typedef struct packed {
    logic                 power_off;  // analog circuitry off
    logic                 sample;     // sample-and-hold tracking
    logic                 group;      // 0 first port group, 1 second
    logic [3:0]           channel;    // channel within the group
    logic [RES_WIDTH-1:0] dac;        // trial code for the comparator
  } adcs_analog_type;

  // table index; code 01 is reserved and timed as 00
  function automatic int adcs_index(input logic [1:0] ctc, input logic [1:0] stc);
    int row;
    row = (ctc == 2'b11) ? 1 : ((ctc == 2'b10) ? 2 : 0);
    return row * 4 + int'(stc);
  endfunction

  // clock-phase units to cpu clocks
  function automatic logic [TIMER_WIDTH-1:0] adcs_cycles(input int units);
    return TIMER_WIDTH'(units * TCL_NS / CLK_PERIOD_NS);
  endfunction

  // sample phase length in cpu clocks
  function automatic logic [TIMER_WIDTH-1:0] adcs_sample(input logic [1:0] ctc,
                                                         input logic [1:0] stc);
    return adcs_cycles(SAMPLE_TCL[adcs_index(ctc, stc)]);
  endfunction

  // one bit-decision step: comparison time shared over all result bits
  function automatic logic [TIMER_WIDTH-1:0] adcs_step(input logic [1:0] ctc,
                                                       input logic [1:0] stc);
    int i;
    i = adcs_index(ctc, stc);
    return adcs_cycles((TOTAL_TCL[i] - SAMPLE_TCL[i] - EXTRA_TCL[i]) / RES_WIDTH);
  endfunction

  // trailing extra phase length
  function automatic logic [TIMER_WIDTH-1:0] adcs_extra(input logic [1:0] ctc,
                                                        input logic [1:0] stc);
    int i;
    i = adcs_index(ctc, stc);
    // extra phase absorbs the rounding of the steps, so the total always holds
    return adcs_cycles(TOTAL_TCL[i]) - adcs_cycles(SAMPLE_TCL[i])
           - TIMER_WIDTH'(RES_WIDTH) * adcs_step(ctc, stc);
  endfunction

  // whole conversion length
  function automatic logic [TIMER_WIDTH-1:0] adcs_total(input logic [1:0] ctc,
                                                        input logic [1:0] stc);
    return adcs_cycles(TOTAL_TCL[adcs_index(ctc, stc)]);
  endfunction
endpackage

`timescale 1ns/1ns
// phase timer: loaded with a length, flags the last cycle of the phase
module adcs_timer (
  input  wire logic                            clock,
  input  wire logic                            srst,
  input  wire logic                            load,
  input  wire logic [adcs_pkg::TIMER_WIDTH-1:0] load_val,
  output logic                                 expire
);
  import adcs_pkg::*;

  logic [TIMER_WIDTH-1:0] cnt;  // cycles left in the phase

  // the phase lasts exactly load_val cycles after the load edge
  assign expire = (cnt == TIMER_WIDTH'(1));

  // count down, reload on request
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (cnt != '0) begin
      cnt <= cnt - TIMER_WIDTH'(1);
    end
  end
endmodule

/* adcs_front_model.sv */
// analog front end model: per-channel input levels, sample-and-hold and comparator
`timescale 1ns/1ns
module adcs_front_model (
  input  wire logic                      clock,
  input  wire adcs_pkg::adcs_analog_type analog,
  input  wire logic [9:0]                level_tab [0:23],
  output logic                           comp_in
);
  import adcs_pkg::*;
  logic [9:0] held;           // value caught by the hold capacitor
  logic       toggle = 1'b0;  // changes every cycle while the circuitry is off
  int         idx;            // selected input: 0..15 first group, 16..23 second
  // second group has 8 inputs only, so channel bit 3 is not used there
  assign idx = analog.group ? 16 + int'(analog.channel[2:0]) : int'(analog.channel);
  // track the selected input while sampling, then hold it
  always @(posedge clock) begin
    toggle <= ~toggle;
    if (analog.sample === 1'b1) begin
      held <= level_tab[idx];
    end
  end
  // comparator: high when the held input is at or above the trial code
  assign comp_in = analog.power_off ? toggle : (held >= analog.dac);
endmodule

/* adcs_tb_top.sv */
// testbench for the converter sequencer: bus tasks, reference queue and scenarios
`timescale 1ns/1ns
module adcs_tb_top;
  import adcs_pkg::*;
  localparam int CAL = 50;  // shortened calibration length
  // conversion and sample lengths in clock-phase units, rows code 00, 11, 10
  localparam int TOT [0:11] = '{388, 436, 532, 724, 772, 868, 1060, 1444, 1540, 1732, 2116, 2884};
  localparam int SMP [0:11] = '{120, 140, 200, 400, 240, 280, 400, 800, 480, 560, 800, 1600};
  logic            clock, srst, hsel, hwrite, hreadyout, hresp, irq, comp_in;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [31:0]     haddr, hwdata, hrdata, seed, rd;
  adcs_analog_type analog;
  logic [9:0]      level_tab [0:23];  // analog input levels
  int              miscompares, n_checks, samp, n;
  int              q[$];              // expected results in start order

  adcs_top #(.CAL_LEN(CAL)) uut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_in(comp_in),
    .analog(analog), .irq(irq));
  adcs_front_model fe (.clock(clock), .analog(analog), .level_tab(level_tab), .comp_in(comp_in));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // counts cycles spent in the sample phase
  always @(posedge clock) begin
    if (analog.sample === 1'b1) begin
      samp <= samp + 1;
    end
  end
  // xorshift random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // waits for hready high at a rising edge, bounded
  task automatic tick_ready();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    tick_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    tick_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk(hresp, 1'b0);
  endtask
  // reset, then follow the calibration until busy clears
  task automatic reset_cal();
    int k;
    srst <= 1'b1;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rdc(OFS_CTRL, 32'h100);
    chk(analog.group, 1'b0);
    k = 3;
    do begin
      bus(1'b0, OFS_CTRL, 32'h0);
      k += 2;
    end while (rd[8] === 1'b1 && k < 4 * CAL);
    if (rd[8] !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    chk(k >= CAL - 1 && k <= CAL + 5, 1);
    rdc(OFS_STATUS, 32'h1);
    bus(1'b0, OFS_RESULT, 32'h0);
    wr(OFS_CLEAR, 32'h3);
    rdc(OFS_STATUS, 32'h0);
  endtask
  // one conversion with the given codes on a random channel of the chosen group
  task automatic convert(input int ctc, input int stc, input logic grp);
    int i, ch;
    i = ((ctc == 3) ? 1 : ((ctc == 2) ? 2 : 0)) * 4 + stc;
    ch = int'(rnd() % 16);
    wr(OFS_MISC, {31'h0, grp});
    q.push_back(int'(level_tab[grp ? 16 + ch % 8 : ch]));
    samp = 0;
    wr(OFS_CTRL, {16'h0, 2'(ctc), 2'(stc), 8'h08, 4'(ch)});
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (irq !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    chk(analog.group, grp);
    chk(analog.channel, grp ? ch % 8 : ch);
    chk(samp, SMP[i] / 2);
    chk(n >= TOT[i] / 2 - 1 && n <= TOT[i] / 2 + 2, 1);
    bus(1'b0, OFS_RESULT, 32'h0);
    chk(rd, q.pop_front());
    wr(OFS_CLEAR, 32'h1);
    @(posedge clock);
    chk(irq, 1'b0);
  endtask

  // main sequence
  initial begin
    seed = 32'h11873289;
    srst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    samp = 0;
    for (int j = 0; j < 24; j++) begin
      level_tab[j] = 10'(rnd());
    end
    @(posedge clock);
    reset_cal();
    $display("test calibration done");
    wr(OFS_MISC, 32'h1);
    rdc(OFS_MISC, 32'h0);
    chk(analog.group, 1'b0);
    wr(OFS_XCFG, 32'h400);
    wr(OFS_MISC, 32'h1);
    rdc(OFS_MISC, 32'h1);
    rdc(8'h1C, 32'h0);
    wr(OFS_ENABLE, 32'h3);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 4; s++) begin
        convert(c, s, 1'(rnd()));
      end
    end
    $display("test timing table done");
    wr(OFS_CTRL, 32'h80);
    wr(OFS_CTRL, 32'h80);
    rdc(OFS_STATUS, 32'h2);
    chk(irq, 1'b1);
    wr(OFS_CTRL, 32'h40);
    repeat (2) @(posedge clock);
    chk(analog.power_off, 1'b1);
    wr(OFS_CLEAR, 32'h3);
    wr(OFS_CTRL, 32'hC0);
    repeat (300) @(posedge clock);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_CTRL, 32'h40);
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    chk(analog.power_off, 1'b0);
    $display("test power off done");
    wr(OFS_CTRL, 32'h80);
    repeat (20) @(posedge clock);
    reset_cal();
    $display("test second reset done");
    finish_test();
  end
endmodule
